// ===== design/inactivity_watchdog_regs.sv
// inactivity watchdog: timeout, trigger mask and state registers, countdown and expiry output
// assumes one system clock, synchronous inputs and a one-cycle read/write strobe register port
`timescale 1ns/1ps
`include "wdt_consts.svh"

module inactivity_watchdog_regs
  import wdt_pkg::*;
#(
  parameter int SEC_CYCLES  = `WDT_SEC_CYCLES,
  parameter int MIN_SECONDS = `WDT_MIN_SECONDS
)
(
  input  wire logic                   i_clk_sys,     // system clock, 250 MHz
  input  wire logic                   i_rst_n,       // synchronous reset, active low
  input  wire logic [`WDT_ADDR_W-1:0] i_addr,        // register offset
  input  wire logic [7:0]             i_wr_data,     // write data
  input  wire logic                   i_wr,          // write strobe
  input  wire logic                   i_rd,          // read strobe
  output logic      [7:0]             o_rd_data,     // read data, cycle after read strobe
  input  wire logic                   i_keyboard_irq, // keyboard_port interrupt request, high active
  input  wire logic                   i_mouse_irq,   // mouse interrupt request, high active
  input  wire logic                   i_ser1_irq,    // first serial port interrupt request
  input  wire logic                   i_ser2_irq,    // second serial port interrupt request
  output logic                        o_expiry_n,    // expiry_output, low while expired
  output logic                        o_wd_irq,      // routed watchdog interrupt, high active
  output logic                        o_irq          // event interrupt, high active level
);

  // ****************************************
  // parameter checks
  // ****************************************
  generate
    if (SEC_CYCLES < 2 || MIN_SECONDS < 1 || MIN_SECONDS > 255)
    begin : g_bad
      $error("inactivity_watchdog_regs: unsupported tick parameters");
    end
  endgenerate

  // ****************************************
  // tick source
  // ****************************************
  logic sec_tick;
  logic min_tick;

  wdt_tick_gen #(
    .SEC_CYCLES  (SEC_CYCLES),
    .MIN_SECONDS (MIN_SECONDS)
  ) u_tick (
    .i_clk_sys  (i_clk_sys),
    .i_rst_n    (i_rst_n),
    .o_sec_tick (sec_tick),
    .o_min_tick (min_tick)
  );

  // ****************************************
  // state
  // ****************************************
  localparam wdt_state_s RESET_STATE = '{
    st:        ST_IDLE,
    timeout:   `WDT_RST_TIMEOUT,
    count:     8'h00,
    trig_mask: `WDT_RST_TRIG_MASK,
    unit_hi:   1'b0,
    unit_lo:   1'b0,
    evt_sts:   2'h0,
    evt_msk:   2'h0,
    route_en:  1'b0,
    rd_data:   8'h00
  };

  wdt_state_s q;
  wdt_state_s d;

  logic [3:0] irq_lines;
  logic       trigger;
  logic       seconds_mode;
  logic       tick;
  logic       expiry_inactive;
  logic       wr_timeout;
  logic       wr_mask;
  logic       wr_state;
  logic       wr_evt_sts;
  logic       wr_evt_msk;
  logic       wr_route;
  logic [1:0] evt_set;

  // ****************************************
  // trigger and tick selection
  // ****************************************
  always_comb
  begin
    irq_lines                    = 4'h0;
    irq_lines[`WDT_MSK_KEY_BIT]   = i_keyboard_irq;
    irq_lines[`WDT_MSK_MOUSE_BIT] = i_mouse_irq;
    irq_lines[`WDT_MSK_SER1_BIT]  = i_ser1_irq;
    irq_lines[`WDT_MSK_SER2_BIT]  = i_ser2_irq;
  end

  // each request counts only with its own mask bit set
  assign trigger = |(irq_lines & q.trig_mask);

  // seconds only once both unit bits are set
  assign seconds_mode = q.unit_hi & q.unit_lo;
  assign tick         = seconds_mode ? sec_tick : min_tick;

  assign expiry_inactive = (q.st != ST_EXPIRED);

  // ****************************************
  // helpers
  // ****************************************
  // strobe qualified by one register offset
  function automatic logic reg_hit
  (
    input logic                   strobe,
    input logic [`WDT_ADDR_W-1:0] addr,
    input logic [`WDT_ADDR_W-1:0] ofs
  );
    reg_hit = strobe && (addr == ofs);
  endfunction

  // state byte: unit bits, expiry level, reserved bits zero
  function automatic logic [7:0] state_byte
  (
    input logic unit_hi,
    input logic unit_lo,
    input logic inactive
  );
    state_byte                      = 8'h00;
    state_byte[`WDT_ST_UNIT_HI_BIT] = unit_hi;
    state_byte[`WDT_ST_UNIT_LO_BIT] = unit_lo;
    state_byte[`WDT_ST_EXPIRY_BIT]  = inactive;
  endfunction

  // ****************************************
  // write decode
  // ****************************************
  assign wr_timeout = reg_hit(i_wr, i_addr, `WDT_OFS_TIMEOUT);
  assign wr_mask    = reg_hit(i_wr, i_addr, `WDT_OFS_TRIG_MASK);
  assign wr_state   = reg_hit(i_wr, i_addr, `WDT_OFS_STATE);
  assign wr_evt_sts = reg_hit(i_wr, i_addr, `WDT_OFS_EVT_STS);
  assign wr_evt_msk = reg_hit(i_wr, i_addr, `WDT_OFS_EVT_MSK);
  assign wr_route   = reg_hit(i_wr, i_addr, `WDT_OFS_ROUTE);

  // ****************************************
  // next state
  // ****************************************
  always_comb
  begin
    d         = q;
    d.rd_data = 8'h00;
    evt_set   = 2'h0;

    // countdown
    // a trigger wins over a tick in the same cycle
    // idle and expired ignore both
    unique case (q.st)
      ST_IDLE:
      begin
        d.count = 8'h00;
      end
      ST_COUNT:
      begin
        if (trigger)
        begin
          d.count                     = q.timeout;
          evt_set[`WDT_EVT_RELOAD_BIT] = 1'b1;
        end
        else if (tick)
        begin
          if (q.count <= 8'h01)
          begin
            d.count                      = 8'h00;
            d.st                         = ST_EXPIRED;
            evt_set[`WDT_EVT_EXPIRED_BIT] = 1'b1;
          end
          else
          begin
            d.count = q.count - 8'h01;
          end
        end
      end
      ST_EXPIRED:
      begin
        d.count = 8'h00;
      end
      default:
      begin
        d.st    = ST_IDLE;
        d.count = 8'h00;
      end
    endcase

    // timeout write overrides countdown and triggers
    if (wr_timeout)
    begin
      d.timeout = i_wr_data;
      d.count   = i_wr_data;
      if (i_wr_data == `WDT_TIMEOUT_OFF)
        d.st = ST_IDLE;
      else
        d.st = ST_COUNT;
      evt_set = 2'h0;
    end

    // mask keeps only the four trigger enables
    if (wr_mask)
      d.trig_mask = i_wr_data[3:0];

    // unit bits: bit 2 only sticks once bit 7 is already set
    if (wr_state)
    begin
      d.unit_hi = i_wr_data[`WDT_ST_UNIT_HI_BIT];
      d.unit_lo = i_wr_data[`WDT_ST_UNIT_LO_BIT] &
                  q.unit_hi &
                  i_wr_data[`WDT_ST_UNIT_HI_BIT];
    end

    // sticky events: write one clears, a new event wins
    if (wr_evt_sts)
      d.evt_sts = (q.evt_sts & ~i_wr_data[1:0]) | evt_set;
    else
      d.evt_sts = q.evt_sts | evt_set;

    // event mask and route enable are plain registers
    if (wr_evt_msk)
      d.evt_msk = i_wr_data[1:0];

    if (wr_route)
      d.route_en = i_wr_data[`WDT_ROUTE_EN_BIT];

    // read data, valid in the cycle after the strobe only
    if (i_rd)
    begin
      unique case (i_addr)
        `WDT_OFS_TIMEOUT:
        begin
          d.rd_data = q.timeout;
        end
        `WDT_OFS_TRIG_MASK:
        begin
          d.rd_data = {4'h0, q.trig_mask};
        end
        `WDT_OFS_STATE:
        begin
          d.rd_data = state_byte(q.unit_hi, q.unit_lo, expiry_inactive);
        end
        `WDT_OFS_EVT_STS:
        begin
          d.rd_data = {6'h00, q.evt_sts};
        end
        `WDT_OFS_EVT_MSK:
        begin
          d.rd_data = {6'h00, q.evt_msk};
        end
        `WDT_OFS_ROUTE:
        begin
          d.rd_data = {7'h00, q.route_en};
        end
        default:
        begin
          d.rd_data = 8'h00;
        end
      endcase
    end
  end

  // ****************************************
  // state register
  // ****************************************
  // reset leaves the timer idle, expiry released, units in minutes
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_n)
      q <= RESET_STATE;
    else
      q <= d;
  end

  // ****************************************
  // outputs
  // ****************************************
  // expiry and routed interrupt follow the state register directly
  assign o_rd_data  = q.rd_data;
  assign o_expiry_n = expiry_inactive;
  assign o_wd_irq   = q.route_en & ~expiry_inactive;
  assign o_irq      = |(q.evt_sts & q.evt_msk);
endmodule

// ===== design/wdt_consts.svh
// register offsets, field positions, reset values and timing counts of the inactivity watchdog
// assumes inclusion by bare name from the package and the design modules
`ifndef WDT_CONSTS_SVH
`define WDT_CONSTS_SVH

// ****************************************
// register offsets
// ****************************************
`define WDT_ADDR_W          3
`define WDT_OFS_TIMEOUT     3'h0
`define WDT_OFS_TRIG_MASK   3'h1
`define WDT_OFS_STATE       3'h2
`define WDT_OFS_EVT_STS     3'h4
`define WDT_OFS_EVT_MSK     3'h5
`define WDT_OFS_ROUTE       3'h6

// ****************************************
// field positions
// ****************************************
`define WDT_MSK_KEY_BIT     0
`define WDT_MSK_MOUSE_BIT   1
`define WDT_MSK_SER1_BIT    2
`define WDT_MSK_SER2_BIT    3
`define WDT_ST_EXPIRY_BIT   0
`define WDT_ST_UNIT_LO_BIT  2
`define WDT_ST_UNIT_HI_BIT  7
`define WDT_EVT_EXPIRED_BIT 0
`define WDT_EVT_RELOAD_BIT  1
`define WDT_ROUTE_EN_BIT    0

// ****************************************
// reset values
// ****************************************
`define WDT_RST_TIMEOUT     8'h00
`define WDT_RST_TRIG_MASK   4'h0
`define WDT_RST_STATE       8'h01
`define WDT_TIMEOUT_OFF     8'h00

// ****************************************
// timing
// ****************************************
`define WDT_CLK_HZ          250000000
`define WDT_TICK_S          1
`define WDT_SEC_CYCLES      (`WDT_CLK_HZ * `WDT_TICK_S)
`define WDT_MIN_SECONDS     60

`endif

// ===== design/wdt_pkg.sv
// types shared by the inactivity watchdog modules
// assumes wdt_consts.svh on the include path
package wdt_pkg;
  `include "wdt_consts.svh"

  typedef enum logic [1:0]
  {
    ST_IDLE    = 2'h0,
    ST_COUNT   = 2'h1,
    ST_EXPIRED = 2'h3
  } wdt_st_e;

  typedef struct packed
  {
    wdt_st_e     st;
    logic [7:0]  timeout;
    logic [7:0]  count;
    logic [3:0]  trig_mask;
    logic        unit_hi;
    logic        unit_lo;
    logic [1:0]  evt_sts;
    logic [1:0]  evt_msk;
    logic        route_en;
    logic [7:0]  rd_data;
  } wdt_state_s;

  typedef struct packed
  {
    logic [31:0] cyc;
    logic [7:0]  secs;
    logic        sec;
    logic        min;
  } tick_state_s;
endpackage

// ===== design/wdt_tick_gen.sv
// second and minute tick generator for the inactivity watchdog
// assumes a free-running system clock and a synchronous active-low reset
`timescale 1ns/1ps
`include "wdt_consts.svh"

module wdt_tick_gen
  import wdt_pkg::*;
#(
  parameter int SEC_CYCLES  = `WDT_SEC_CYCLES,
  parameter int MIN_SECONDS = `WDT_MIN_SECONDS
)
(
  input  wire logic i_clk_sys,   // system clock
  input  wire logic i_rst_n,     // synchronous reset, active low
  output logic      o_sec_tick,  // one-cycle pulse per second
  output logic      o_min_tick   // one-cycle pulse per minute
);

  generate
    if (SEC_CYCLES < 2 || MIN_SECONDS < 1 || MIN_SECONDS > 255)
    begin : g_bad
      $error("wdt_tick_gen: unsupported tick parameters");
    end
  endgenerate

  localparam logic [31:0] SEC_LAST = 32'(SEC_CYCLES - 1);
  localparam logic [7:0]  MIN_LAST = 8'(MIN_SECONDS - 1);

  tick_state_s q;
  tick_state_s d;

  // ****************************************
  // prescaler
  // ****************************************
  always_comb
  begin
    d     = q;
    d.sec = 1'b0;
    d.min = 1'b0;
    if (q.cyc == SEC_LAST)
    begin
      d.cyc = 32'h0000_0000;
      d.sec = 1'b1;
      if (q.secs == MIN_LAST)
      begin
        d.secs = 8'h00;
        d.min  = 1'b1;
      end
      else
      begin
        d.secs = q.secs + 8'h01;
      end
    end
    else
    begin
      d.cyc = q.cyc + 32'h0000_0001;
    end
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_n)
      q <= '0;
    else
      q <= d;
  end

  assign o_sec_tick = q.sec;
  assign o_min_tick = q.min;
endmodule

// ===== tb/test_inactivity_watchdog_regs.sv
// self-checking bench for the inactivity watchdog registers
// assumes 10 cycles a second and 3 seconds a minute
`timescale 1ns/1ps
`include "wdt_consts.svh"

module test_inactivity_watchdog_regs
  import wdt_pkg::*;
;
  logic                   clk_sys, rst_n, wr, rd, go, keyboard, mouse, ser1, ser2;
  logic                   expiry_n, wd_irq, irq;
  logic [`WDT_ADDR_W-1:0] addr;
  logic [7:0]             wdata, rdata;
  logic [1:0]             sel;
  int                     fail_count, total_checks;

  inactivity_watchdog_regs #(.SEC_CYCLES(10), .MIN_SECONDS(3)) dut
  (
    .i_clk_sys(clk_sys), .i_rst_n(rst_n), .i_addr(addr), .i_wr_data(wdata),
    .i_wr(wr), .i_rd(rd), .o_rd_data(rdata), .i_keyboard_irq(keyboard), .i_mouse_irq(mouse),
    .i_ser1_irq(ser1), .i_ser2_irq(ser2), .o_expiry_n(expiry_n), .o_wd_irq(wd_irq), .o_irq(irq)
  );
  wdt_irq_src src
  (
    .i_clk_sys(clk_sys), .i_go(go), .i_sel(sel),
    .o_keyboard(keyboard), .o_mouse(mouse), .o_ser1(ser1), .o_ser2(ser2)
  );

  // ****
  // tasks
  // ****
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic wr_reg(input logic [2:0] a, input logic [7:0] v);
    @(posedge clk_sys);
    wr <= 1'b1;
    addr <= a;
    wdata <= v;
    @(posedge clk_sys);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [2:0] a, input logic [7:0] e);
    @(posedge clk_sys);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk_sys);
    rd <= 1'b0;
    #1;
    chk(rdata, e);
  endtask
  task automatic pulse(input int s);
    @(posedge clk_sys);
    go <= 1'b1;
    sel <= s[1:0];
    @(posedge clk_sys);
    go <= 1'b0;
    wt(3);
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // ****
  // clock, watchdog, tests
  // ****
  initial
  begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  initial
  begin
    #20000;
    fail_count++;
    stop_test();
  end
  initial
  begin
    {rst_n, wr, rd, go, sel, addr, wdata} = '0;
    repeat (10) @(posedge clk_sys);
    rst_n <= 1'b1;
    rd_reg(3'h0, 8'h00);
    rd_reg(3'h1, 8'h00);
    rd_reg(3'h2, 8'h01);
    rd_reg(3'h3, 8'h00);
    rd_reg(3'h7, 8'h00);
    $display("reset test done");
    wr_reg(3'h0, 8'h02);
    wt(30);
    chk({7'h0, expiry_n}, 8'h01);
    wt(32);
    chk({7'h0, expiry_n}, 8'h00);
    rd_reg(3'h2, 8'h00);
    $display("minute test done");
    wr_reg(3'h1, 8'hFF);
    rd_reg(3'h1, 8'h0F);
    wr_reg(3'h2, 8'h04);
    rd_reg(3'h2, 8'h00);
    wr_reg(3'h2, 8'h84);
    rd_reg(3'h2, 8'h80);
    wr_reg(3'h1, 8'h00);
    wr_reg(3'h2, 8'h80);
    wr_reg(3'h2, 8'h84);
    wr_reg(3'h4, 8'h03);
    wr_reg(3'h0, 8'h03);
    rd_reg(3'h2, 8'h85);
    wt(17);
    chk({7'h0, expiry_n}, 8'h01);
    wt(12);
    chk({7'h0, expiry_n}, 8'h00);
    rd_reg(3'h2, 8'h84);
    rd_reg(3'h4, 8'h01);
    chk({7'h0, irq}, 8'h00);
    wr_reg(3'h5, 8'h01);
    wt(1);
    chk({7'h0, irq}, 8'h01);
    wr_reg(3'h4, 8'h01);
    wt(1);
    chk({7'h0, irq}, 8'h00);
    wr_reg(3'h6, 8'h01);
    wt(1);
    chk({7'h0, wd_irq}, 8'h01);
    wr_reg(3'h0, 8'h00);
    wt(40);
    chk({6'h0, wd_irq, expiry_n}, 8'h01);
    rd_reg(3'h2, 8'h85);
    $display("second test done");
    for (int i = 0; i < 4; i++)
    begin
      wr_reg(3'h1, 8'h01 << i);
      wr_reg(3'h0, 8'h02);
      repeat (8) pulse(i);
      chk({7'h0, expiry_n}, 8'h01);
      wr_reg(3'h1, 8'h0F ^ (8'h01 << i));
      repeat (6) pulse(i);
      chk({7'h0, expiry_n}, 8'h00);
    end
    rd_reg(3'h4, 8'h03);
    $display("trigger test done");
    stop_test();
  end
endmodule

// ===== tb/wdt_asserts.sv
// checker on the watchdog register port and expiry pins
// assumes binding into inactivity_watchdog_regs
`timescale 1ns/1ps
`include "wdt_consts.svh"

module wdt_asserts
(
  input wire logic                   i_clk_sys,  // clock
  input wire logic                   i_rst_n,    // reset, active low
  input wire logic [`WDT_ADDR_W-1:0] i_addr,     // offset
  input wire logic [7:0]             i_wr_data,  // write data
  input wire logic                   i_wr,       // write strobe
  input wire logic                   i_rd,       // read strobe
  input wire logic [7:0]             o_rd_data,  // read data
  input wire logic                   o_expiry_n, // expiry, low active
  input wire logic                   o_wd_irq,   // routed interrupt
  input wire logic                   o_irq       // event interrupt
);
  // ****
  // properties
  // ****
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);
  logic to_wr;
  assign to_wr = i_wr && i_addr == `WDT_OFS_TIMEOUT;

  unmapped_reads_zero_a: assert property (i_rd && i_addr[1:0] == 2'h3 |=> o_rd_data == 8'h00)
    else $error("unmapped read not zero");
  mask_reserved_zero_a: assert property (i_rd && i_addr == `WDT_OFS_TRIG_MASK |=> o_rd_data[7:4] == 4'h0)
    else $error("mask reserved bits set");
  state_reserved_zero_a: assert property (i_rd && i_addr == `WDT_OFS_STATE |=> (o_rd_data & 8'h7A) == 8'h00)
    else $error("state reserved bits set");
  state_mirror_a: assert property (i_rd && i_addr == `WDT_OFS_STATE |=> o_rd_data[0] == $past(o_expiry_n))
    else $error("state bit differs from expiry pin");
  load_release_a: assert property (to_wr |=> o_expiry_n)
    else $error("timeout write left expiry low");
  zero_idle_a: assert property (to_wr && i_wr_data == 8'h00 |=> (o_expiry_n && !o_wd_irq) [*3])
    else $error("zero timeout not idle");
  expiry_holds_a: assert property (!o_expiry_n && !to_wr |=> !o_expiry_n)
    else $error("expiry released without write");
  routed_irq_a: assert property (o_wd_irq |-> !o_expiry_n)
    else $error("routed irq while not expired");
endmodule

bind inactivity_watchdog_regs wdt_asserts u_wdt_asserts
(
  .i_clk_sys, .i_rst_n, .i_addr, .i_wr_data, .i_wr, .i_rd,
  .o_rd_data, .o_expiry_n, .o_wd_irq, .o_irq
);

// ===== tb/wdt_irq_src.sv
// peripheral interrupt request lines seen by the watchdog
// assumes the bench changes requests right after a rising edge
`timescale 1ns/1ps

module wdt_irq_src
(
  input  wire logic       i_clk_sys, // clock
  input  wire logic       i_go,      // raise one request for a cycle
  input  wire logic [1:0] i_sel,     // 0 keyboard, 1 mouse, 2 ser1, 3 ser2
  output logic            o_keyboard, // keyboard_port request
  output logic            o_mouse,   // mouse request
  output logic            o_ser1,    // first serial request
  output logic            o_ser2     // second serial request
);
  logic [3:0] line_q;
  always_ff @(posedge i_clk_sys)
    line_q <= i_go ? (4'h1 << i_sel) : 4'h0;
  assign {o_ser2, o_ser1, o_mouse, o_keyboard} = line_q;
endmodule
